// ### sdp_pkg.sv
package sdp_pkg;
  // timing
  localparam int CLK_NS  = 10;
  localparam int ABL_NS  = 3;
  localparam int ABL_CYC = (ABL_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] ABL_LAST = 2'(ABL_CYC - 1);
  // widths
  localparam int WORD_W = 24;
  localparam int CTL_W  = 16;
  localparam int INT_W  = 9;
  localparam int FRAC_W = 12;
  localparam int R_W    = 4;
  localparam int MON_W  = 3;
  localparam int NS_W   = 9;
  localparam int FBR_W  = 10;
  // field positions
  localparam int SEL_LSB   = 0;
  localparam int FS_BIT    = 23;
  localparam int INT_LSB   = 14;
  localparam int FRAC_LSB  = 2;
  localparam int MOD_LSB   = 2;
  localparam int R_LSB     = 14;
  localparam int PRE_BIT   = 18;
  localparam int MON_LSB   = 20;
  localparam int DBL_BIT   = 11;
  localparam int PDPOL_BIT = 6;
  localparam int PWD_BIT   = 4;
  localparam int TRI_BIT   = 3;
  localparam int CRST_BIT  = 2;
  localparam int NS_LSB    = 2;
  // latch select codes
  localparam logic [1:0] SEL_FB  = 2'h0;
  localparam logic [1:0] SEL_REF = 2'h1;
  localparam logic [1:0] SEL_CTL = 2'h2;
  localparam logic [1:0] SEL_NS  = 2'h3;
  // value limits
  localparam logic [INT_W-1:0]  INT_MIN = 9'h01F;
  localparam logic [FRAC_W-1:0] MOD_MIN = 12'h002;
  localparam logic [R_W-1:0]    R_MIN   = 4'h1;
  // reset values
  localparam logic [WORD_W-1:0] RST_FB  = 24'h07C000;
  localparam logic [WORD_W-1:0] RST_REF = 24'h004009;
  localparam logic [CTL_W-1:0]  RST_CTL = 16'h0002;
  localparam logic [WORD_W-1:0] RST_NS  = 24'h000003;
  // monitor select codes
  localparam logic [MON_W-1:0] MON_LOW  = 3'h0;
  localparam logic [MON_W-1:0] MON_HIGH = 3'h1;
  localparam logic [MON_W-1:0] MON_REF  = 3'h2;
  localparam logic [MON_W-1:0] MON_FB   = 3'h3;
  localparam logic [MON_W-1:0] MON_PUMP = 3'h4;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic strobe;
  } sdp_ser_t;

  typedef struct packed {
    logic up;
    logic dn;
    logic en;
  } sdp_pump_t;
endpackage

// ### sdp_div_cnt.sv
`timescale 1ns/1ns
module sdp_div_cnt #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // control
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  // output
  output logic              pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } sdp_cnt_st_t;

  sdp_cnt_st_t st;
  sdp_cnt_st_t next_st;

  if (W < 2) begin : g_chk
    $error("sdp_div_cnt: W must be at least 2");
  end

  // count runs 1..ratio; a ratio below one behaves as one
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (clr) begin
      next_st.cnt = W'(1);
    end else if (tick) begin
      if (st.cnt >= ratio) begin
        next_st.cnt = W'(1);
        next_st.pulse = 1'b1;
      end else begin
        next_st.cnt = st.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{cnt: W'(1), pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
endmodule

// ### sdp_core.sv
`timescale 1ns/1ns
module sdp_core (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // serial programming pins
  input  wire sdp_pkg::sdp_ser_t  ser,
  // frequency inputs
  input  wire logic               reference_input,
  input  wire logic               feedback_input,
  // charge pump drive
  output sdp_pkg::sdp_pump_t      pump,
  // status and configuration outputs
  output logic                    monitor_output_pin,
  output logic                    ref_stage_connect,
  output logic                    fast_settle_bit,
  output logic                    prescaler_sel,
  output logic [8:0]              noise_spur_cfg
);
  import sdp_pkg::*;

  typedef struct packed {
    logic               sclk_q;
    logic               strobe_q;
    logic               ref_q;
    logic               fb_q;
    logic [WORD_W-1:0]  shreg;
    logic [WORD_W-1:0]  fb_word;
    logic [WORD_W-1:0]  ref_word;
    logic [CTL_W-1:0]   ctl_word;
    logic [WORD_W-1:0]  ns_word;
    logic [FRAC_W-1:0]  mod_active;
    logic [FRAC_W-1:0]  acc;
    logic               carry;
    logic               up;
    logic               dn;
    logic [1:0]         abl_cnt;
    logic               ref_tog;
    logic               fb_tog;
    sdp_pump_t          pump;
    logic               mon;
    logic               ref_conn;
  } sdp_st_t;

  sdp_st_t st;
  sdp_st_t next_st;

  logic              sclk_rise;
  logic              strobe_rise;
  logic              ref_rise;
  logic              ref_fall;
  logic              fb_rise;
  logic              pwd;
  logic              dbl;
  logic              halt;
  logic              ref_tick;
  logic              ref_p;
  logic              fb_p;
  logic [INT_W-1:0]  int_raw;
  logic [INT_W-1:0]  int_eff;
  logic [FRAC_W-1:0] frac_raw;
  logic [FRAC_W-1:0] frac_eff;
  logic [FRAC_W-1:0] mod_eff;
  logic [R_W-1:0]    r_raw;
  logic [R_W-1:0]    r_eff;
  logic [FBR_W-1:0]  fb_ratio;
  logic [FRAC_W:0]   acc_sum;
  logic              both;
  logic              abl_done;

  // edges; pins are synchronous to core_clk
  assign sclk_rise   = ser.sclk & ~st.sclk_q;
  assign strobe_rise = ser.strobe & ~st.strobe_q;
  assign ref_rise    = reference_input & ~st.ref_q;
  assign ref_fall    = ~reference_input & st.ref_q;
  assign fb_rise     = feedback_input & ~st.fb_q;

  assign pwd  = st.ctl_word[PWD_BIT];
  assign dbl  = st.ctl_word[DBL_BIT];
  assign halt = pwd | st.ctl_word[CRST_BIT];

  // word fields; out-of-range values are clamped rather than trusted
  assign int_raw  = st.fb_word[INT_LSB +: INT_W];
  assign frac_raw = st.fb_word[FRAC_LSB +: FRAC_W];
  assign int_eff  = (int_raw < INT_MIN) ? INT_MIN : int_raw;
  assign mod_eff  = (st.mod_active < MOD_MIN) ? MOD_MIN : st.mod_active;
  assign frac_eff = (frac_raw >= mod_eff) ? mod_eff - FRAC_W'(1) : frac_raw;
  assign r_raw    = st.ref_word[R_LSB +: R_W];
  assign r_eff    = (r_raw < R_MIN) ? R_MIN : r_raw;

  // doubler counts both reference edges, doubling the rate into R
  assign ref_tick = ~pwd & (ref_rise | (dbl & ref_fall));

  // integer plus carry from the fractional accumulator
  assign fb_ratio = FBR_W'(int_eff) + FBR_W'(st.carry);
  assign acc_sum  = {1'b0, st.acc} + {1'b0, frac_eff};

  assign both     = st.up & st.dn;
  assign abl_done = both && (st.abl_cnt == ABL_LAST);

  sdp_div_cnt #(.W(R_W)) u_ref_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clr      (halt),
    .tick     (ref_tick),
    .ratio    (r_eff),
    .pulse    (ref_p)
  );

  sdp_div_cnt #(.W(FBR_W)) u_fb_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clr      (halt),
    .tick     (fb_rise),
    .ratio    (fb_ratio),
    .pulse    (fb_p)
  );

  always_comb begin
    next_st = st;
    next_st.sclk_q   = ser.sclk;
    next_st.strobe_q = ser.strobe;
    next_st.ref_q    = reference_input;
    next_st.fb_q     = feedback_input;
    if (sclk_rise) begin
      next_st.shreg = {st.shreg[WORD_W-2:0], ser.sdata};
    end
    // the latch sees the word as it stood before this cycle's shift
    if (strobe_rise) begin
      unique case (st.shreg[SEL_LSB +: 2])
        SEL_FB: begin
          next_st.fb_word    = st.shreg;
          next_st.mod_active = st.ref_word[MOD_LSB +: FRAC_W];
        end
        SEL_REF: next_st.ref_word = st.shreg;
        SEL_CTL: next_st.ctl_word = st.shreg[CTL_W-1:0];
        SEL_NS:  next_st.ns_word = st.shreg;
      endcase
    end
    // first-order accumulator chooses int or int+1 for the next cycle
    if (halt) begin
      next_st.acc   = '0;
      next_st.carry = 1'b0;
    end else if (fb_p) begin
      if (acc_sum >= {1'b0, mod_eff}) begin
        next_st.acc   = FRAC_W'(acc_sum - {1'b0, mod_eff});
        next_st.carry = 1'b1;
      end else begin
        next_st.acc   = acc_sum[FRAC_W-1:0];
        next_st.carry = 1'b0;
      end
    end
    // phase detector; a new edge in the clearing cycle still sets
    if (halt) begin
      next_st.up      = 1'b0;
      next_st.dn      = 1'b0;
      next_st.abl_cnt = '0;
    end else begin
      next_st.up      = (st.up & ~abl_done) | ref_p;
      next_st.dn      = (st.dn & ~abl_done) | fb_p;
      next_st.abl_cnt = (both && !abl_done) ? st.abl_cnt + 2'h1 : 2'h0;
    end
    next_st.ref_tog = st.ref_tog ^ ref_p;
    next_st.fb_tog  = st.fb_tog ^ fb_p;
    // pump drive: polarity swaps senses, three-state or power-down idles it
    next_st.pump.en = ~st.ctl_word[TRI_BIT] & ~pwd;
    if (st.ctl_word[PDPOL_BIT]) begin
      next_st.pump.up = next_st.up;
      next_st.pump.dn = next_st.dn;
    end else begin
      next_st.pump.up = next_st.dn;
      next_st.pump.dn = next_st.up;
    end
    next_st.ref_conn = ~pwd;
    case (st.ref_word[MON_LSB +: MON_W])
      MON_LOW:  next_st.mon = 1'b0;
      MON_HIGH: next_st.mon = 1'b1;
      MON_REF:  next_st.mon = st.ref_tog;
      MON_FB:   next_st.mon = st.fb_tog;
      MON_PUMP: next_st.mon = st.up | st.dn;
      default:  next_st.mon = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st            <= '0;
      st.fb_word    <= RST_FB;
      st.ref_word   <= RST_REF;
      st.ctl_word   <= RST_CTL;
      st.ns_word    <= RST_NS;
      st.mod_active <= MOD_MIN;
      st.ref_conn   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign pump               = st.pump;
  assign monitor_output_pin = st.mon;
  assign ref_stage_connect  = st.ref_conn;
  assign fast_settle_bit    = st.fb_word[FS_BIT];
  assign prescaler_sel      = st.ref_word[PRE_BIT];
  assign noise_spur_cfg     = st.ns_word[NS_LSB +: NS_W];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  shift_in_a: assert property (
    sclk_rise |=> st.shreg == {$past(st.shreg[WORD_W-2:0]), $past(ser.sdata)})
    else $error("shift register did not take the data bit");

  shift_hold_a: assert property (
    !sclk_rise |=> $stable(st.shreg))
    else $error("shift register moved without a serial clock edge");

  fb_latch_a: assert property (
    strobe_rise && st.shreg[1:0] == 2'h0 |=> st.fb_word == $past(st.shreg)
      && $stable(st.ctl_word) && $stable(st.ref_word))
    else $error("feedback latch load wrong");

  sel_decode_a: assert property (
    strobe_rise && st.shreg[1:0] == 2'h2 |=>
      st.ctl_word == $past(st.shreg[15:0]) && $stable(st.fb_word))
    else $error("control latch load wrong");

  ref_latch_a: assert property (
    strobe_rise && st.shreg[1:0] == 2'h1 |=>
      st.ref_word == $past(st.shreg) && $stable(st.ns_word))
    else $error("reference latch load wrong");

  den_wait_a: assert property (
    !(strobe_rise && st.shreg[1:0] == 2'h0) |=> $stable(st.mod_active))
    else $error("denominator changed without a feedback write");

  den_apply_a: assert property (
    strobe_rise && st.shreg[1:0] == 2'h0 |=>
      st.mod_active == $past(st.ref_word[13:2]))
    else $error("denominator not applied on feedback write");

  int_range_a: assert property (
    int_eff >= 9'h01F && (int_raw < 9'h01F || int_eff == int_raw))
    else $error("whole divide value out of range");

  frac_range_a: assert property (
    mod_eff >= 12'h002 && frac_eff < mod_eff)
    else $error("numerator or denominator out of range");

  ref_div_a: assert property (
    ref_p |=> !ref_p)
    else $error("reference divider pulsed twice in a row");

  abl_end_a: assert property (
    both && !ref_p && !fb_p |=> !st.up && !st.dn)
    else $error("anti-backlash overlap not ended");

  pwd_iso_a: assert property (
    pwd |=> !ref_stage_connect ##0 !ref_p[*2])
    else $error("reference stage still active in power-down");

  mon_sel_a: assert property (
    st.ref_word[22:20] == 3'h1 |=> monitor_output_pin)
    else $error("monitor pin not driven high when selected");
endmodule

// ### sdp_host.sv
`timescale 1ns/1ns
module sdp_host (
  // clock
  input  wire logic        core_clk,
  // serial programming pins
  output sdp_pkg::sdp_ser_t ser
);
  import sdp_pkg::*;

  initial begin
    ser = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // each level is held two core cycles so the sampled pins never miss an edge
  task automatic send(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      ser.sdata <= w[i];
      ser.sclk  <= 1'b0;
      tick(2);
      ser.sclk <= 1'b1;
      tick(2);
    end
    ser.sclk  <= 1'b0;
    // released data line shows no stale bit
    ser.sdata <= ~w[0];
    tick(2);
    ser.strobe <= 1'b1;
    tick(2);
    ser.strobe <= 1'b0;
    tick(2);
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sdp_pkg::*;
  logic              core_clk;
  logic              rst_b;
  logic              reference_input;
  logic              feedback_input;
  sdp_ser_t          ser;
  sdp_pump_t         pump;
  logic              monitor_output_pin;
  logic              ref_stage_connect;
  logic              fast_settle_bit;
  logic              prescaler_sel;
  logic [8:0]        noise_spur_cfg;
  logic [WORD_W-1:0] lat [4];
  logic [WORD_W-1:0] w;
  int                n_errors;
  int                checked;
  int                seed;

  sdp_core sdp_core_inst (
    .core_clk           (core_clk),
    .rst_b              (rst_b),
    .ser                (ser),
    .reference_input    (reference_input),
    .feedback_input     (feedback_input),
    .pump               (pump),
    .monitor_output_pin (monitor_output_pin),
    .ref_stage_connect  (ref_stage_connect),
    .fast_settle_bit    (fast_settle_bit),
    .prescaler_sel      (prescaler_sel),
    .noise_spur_cfg     (noise_spur_cfg)
  );

  sdp_host sdp_host_inst (
    .core_clk (core_clk),
    .ser      (ser)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_val(input logic [8:0] got, input logic [8:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // divider counts may be off by one from the phase at which counting starts
  task automatic check_cnt(input int got, input int exp, input string what);
    checked++;
    if (got < exp - 1 || got > exp + 1) begin
      n_errors++;
      $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic check_all();
    @(negedge core_clk);
    check_val(9'(fast_settle_bit), 9'(lat[SEL_FB][FS_BIT]), "fast settle");
    check_val(9'(prescaler_sel), 9'(lat[SEL_REF][PRE_BIT]), "prescaler");
    check_val(noise_spur_cfg, lat[SEL_NS][10:2], "noise");
    check_val(9'(ref_stage_connect), 9'(!lat[SEL_CTL][PWD_BIT]), "ref stage");
    check_val(9'(pump.en), 9'(!(lat[SEL_CTL][PWD_BIT] | lat[SEL_CTL][TRI_BIT])), "pump en");
    if (lat[SEL_REF][22:21] == 2'h0) begin
      check_val(9'(monitor_output_pin), 9'(lat[SEL_REF][20]), "monitor");
    end
  endtask

  task automatic write_word(input logic [WORD_W-1:0] wd);
    @(posedge core_clk);
    sdp_host_inst.send(wd);
    lat[wd[1:0]] = (wd[1:0] == SEL_CTL) ? {8'h00, wd[15:0]} : wd;
  endtask

  task automatic run_in(input bit fb, input int n, output int cnt);
    logic last;
    cnt = 0;
    @(negedge core_clk);
    last = monitor_output_pin;
    for (int k = 0; k < n * 6; k++) begin
      @(posedge core_clk);
      if (fb) begin
        feedback_input <= (k % 6 < 3);
      end else begin
        reference_input <= (k % 6 < 3);
      end
      @(negedge core_clk);
      if (monitor_output_pin !== last) cnt++;
      last = monitor_output_pin;
    end
  endtask

  task automatic div_case(input logic [WORD_W-1:0] rw, cw, fw, input bit fb, input int n, e);
    int t;
    write_word(cw);
    write_word(rw);
    write_word(fw);
    run_in(fb, n, t);
    check_cnt(t, e, "divider");
  endtask

  initial begin
    seed = 32'hfe1d;
    n_errors = 0;
    checked = 0;
    rst_b = 1'b0;
    reference_input = 1'b0;
    feedback_input = 1'b0;
    lat[0] = RST_FB;
    lat[1] = RST_REF;
    lat[2] = {8'h00, RST_CTL};
    lat[3] = RST_NS;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    check_all();
    for (int i = 0; i < 16; i++) begin
      w = 24'($random(seed));
      w[1:0] = 2'(i);
      write_word(w);
      check_all();
    end
    for (int c = 0; c < 2; c++) begin
      write_word(24'h004009 | (24'(c) << MON_LSB));
      check_all();
    end
    div_case(24'h214009, 24'h000002, 24'h07C000, 1'b0, 50, 10);
    // only reference pulses so far: up stays set, swapped onto the dn drive
    check_val(9'({pump.up, pump.dn}), 9'h001, "pump sense ref");
    div_case(24'h214009, 24'h000802, 24'h07C000, 1'b0, 50, 20);
    div_case(24'h214009, 24'h000012, 24'h07C000, 1'b0, 50, 0);
    check_all();
    div_case(24'h304009, 24'h000002, 24'h07C000, 1'b1, 62, 2);
    // power-down cleared the detector; only feedback pulses since
    check_val(9'({pump.up, pump.dn}), 9'h002, "pump sense fb");
    div_case(24'h304009, 24'h000002, 24'h014000, 1'b1, 62, 2);
    finish_test();
  end

  // whole run needs under ten thousand cycles
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule
